/* File: hdl/switch_fault_manager.sv */
// Fault manager of a sixteen-output low-side switch: 24-bit serial slave,
// command apply, open-load filter, fault latching and output protection.
// Assumes a 10 MHz core clock; all pins are asynchronous to it.
//
// How it works
// RULE1: Past 24 bits, received bits shift out again, a 24-bit delay stage.
// RULE2: The first 24 bits out of a frame are the fault status word.
// RULE3: On chip-select rise the last 24 received bits are applied as command.
// RULE4: Master should send 48 bits after reset and compare the echo.
// RULE5: Open load is checked only on outputs commanded off, per-output comparator.
// RULE6: Pull-down off at reset; stays on until sleep or disable command.
// RULE7: Chip-select rise starts a filter; open-load compare ignored until expiry.
// RULE8: A detected open load stays latched in the response word.
// RULE9: Without fast-shutdown-disable, persistent high drain voltage in limit turns off.
// RULE10: Thermal limit turns only that output off until cooled, then retries; code retries only with global bit 17 high.
// RULE11: Current limit, short and thermal events set response bit 23.
// RULE12: Logic supply undervoltage turns outputs off and resets control registers.
// RULE13: Load supply undervoltage turns outputs off and resets the device.
// RULE14: After cooling, global bit 17 selects staying off or retrying.
// RULE15: All response fault bits clear on chip-select rise.
// RULE16: Bits 15..0 per output, 21..16 zero, 22 overvoltage, 23 any fault.
// RULE17: Bit 17 low keeps cooled outputs off; high lets them retry.
// RULE18: Words travel most significant bit first.
// RULE19: Detector outputs pass a two-stage synchronizer before the fault logic.
// RULE20: Filter and shutdown delays are core-clock counters.
`timescale 1ns/1ps
`include "switch_fault_defs.svh"

module switch_fault_manager #(
   parameter int SHORT_CYC = `SHORT_CYC
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Serial link
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_mosi,
   output logic o_miso,
   output logic o_miso_oe_n,
   // Supply monitors
   input wire logic i_uv_logic_supply,
   input wire logic i_uv_load_supply,
   input wire logic i_ov_load_supply,
   // Per-output detectors
   input wire logic [15:0] i_ilim,
   input wire logic [15:0] i_vds_hi,
   input wire logic [15:0] i_otemp,
   input wire logic [15:0] i_ol_cmp,
   // Drives
   output logic [15:0] o_low_side_outputs,
   output logic [15:0] o_ol_pulldown_en,
   output logic o_ov_resume
);
   localparam int SW = 70;
   localparam logic [11:0] FILT_LOAD = 12'(`FILT_CYC);

   logic [SW-1:0] sync1_ff;
   logic [SW-1:0] sync2_ff;
   logic sclk_s, cs_n_s, mosi_s, uvl_s, uvp_s, ov_s;
   logic [15:0] ilim_s, vds_s, otemp_s, olcmp_s;
   logic sclk_d_ff, cs_d_ff;
   logic sclk_rise, sclk_fall, cs_rise, cs_fall, dev_clr;
   logic [23:0] sr_ff;
   logic [5:0] bit_cnt_ff;
   logic [11:0] filt_cnt_ff;
   logic [15:0] onoff_ff, ol_en_ff, short_dis_ff;
   logic retry_ff;
   logic [15:0] fault_ff;
   logic glob_ff;
   logic [15:0] ol_set, chan_set, short_evt, therm_evt;
   logic [23:0] status;
   logic apply;

   function automatic logic op_is(input logic [23:0] w, input logic [5:0] op);
      op_is = (w[`OP_MSB:`OP_LSB] == op);
   endfunction

   // ----------------------------------------------------------------------
   // Input synchronizers
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         sync1_ff <= {6'h10, 64'h0000_0000_0000_0000}; // cs_n idle high
         sync2_ff <= {6'h10, 64'h0000_0000_0000_0000};
      end else begin
         sync1_ff <= {i_sclk, i_cs_n, i_mosi, i_uv_logic_supply, i_uv_load_supply, i_ov_load_supply,
                      i_ilim, i_vds_hi, i_otemp, i_ol_cmp}; // [RULE19]
         sync2_ff <= sync1_ff;
      end
   end

   assign {sclk_s, cs_n_s, mosi_s, uvl_s, uvp_s, ov_s, ilim_s, vds_s, otemp_s, olcmp_s} = sync2_ff;
   assign dev_clr = uvl_s | uvp_s; // [RULE12] [RULE13]

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         sclk_d_ff <= 1'b0;
         cs_d_ff <= 1'b1;
      end else begin
         sclk_d_ff <= sclk_s;
         cs_d_ff <= cs_n_s;
      end
   end

   assign sclk_rise = ~cs_n_s & sclk_s & ~sclk_d_ff;
   assign sclk_fall = ~cs_n_s & ~sclk_s & sclk_d_ff;
   assign cs_rise = cs_n_s & ~cs_d_ff;
   assign cs_fall = ~cs_n_s & cs_d_ff;

   // ----------------------------------------------------------------------
   // Shift stage
   // ----------------------------------------------------------------------
   assign status = {glob_ff | ov_s, ov_s, 6'h00, fault_ff}; // [RULE16]

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         sr_ff <= 24'h00_0000;
         bit_cnt_ff <= 6'h00;
         o_miso <= 1'b0;
      end else if (cs_fall) begin
         sr_ff <= status; // [RULE2]
         bit_cnt_ff <= 6'h00;
         o_miso <= status[23]; // [RULE18]
      end else if (sclk_rise) begin
         sr_ff <= {sr_ff[22:0], mosi_s}; // [RULE1] [RULE18]
         bit_cnt_ff <= (bit_cnt_ff == 6'h3F) ? bit_cnt_ff : bit_cnt_ff + 6'h01;
      end else if (sclk_fall) begin
         o_miso <= sr_ff[23]; // [RULE1]
      end
   end

   assign o_miso_oe_n = cs_n_s;
   assign apply = cs_rise & (bit_cnt_ff >= 6'h18) & ~dev_clr;

   // ----------------------------------------------------------------------
   // Command apply
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         onoff_ff <= `REG16_RST;
         ol_en_ff <= `REG16_RST;
         short_dis_ff <= `REG16_RST;
         retry_ff <= 1'b0;
         o_ov_resume <= 1'b0;
      end else if (dev_clr || (apply && op_is(sr_ff, `OP_RESET))) begin
         onoff_ff <= `REG16_RST; // [RULE12] [RULE6]
         ol_en_ff <= `REG16_RST;
         short_dis_ff <= `REG16_RST;
         retry_ff <= 1'b0;
         o_ov_resume <= 1'b0;
      end else if (apply) begin
         if (op_is(sr_ff, `OP_ONOFF)) begin
            onoff_ff <= sr_ff[15:0]; // [RULE3]
         end
         if (op_is(sr_ff, `OP_OL_EN)) begin
            ol_en_ff <= sr_ff[15:0]; // [RULE6]
         end
         if (op_is(sr_ff, `OP_SHORT_OFF_DIS)) begin
            short_dis_ff <= sr_ff[15:0];
         end
         if (op_is(sr_ff, `OP_GLOBAL)) begin
            retry_ff <= sr_ff[`GLOBAL_RETRY_BIT]; // [RULE14]
            o_ov_resume <= sr_ff[`GLOBAL_OV_BIT];
         end
      end
   end

   assign o_ol_pulldown_en = ol_en_ff;

   // ----------------------------------------------------------------------
   // Open-load filter and fault latch
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         filt_cnt_ff <= 12'h000;
      end else if (cs_rise) begin
         filt_cnt_ff <= FILT_LOAD; // [RULE7] [RULE20]
      end else if (filt_cnt_ff != 12'h000) begin
         filt_cnt_ff <= filt_cnt_ff - 12'h001;
      end
   end

   assign ol_set = olcmp_s & ~onoff_ff & ol_en_ff & {16{filt_cnt_ff == 12'h000}}; // [RULE5] [RULE7]
   assign chan_set = ol_set | (ilim_s & onoff_ff) | short_evt | therm_evt;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         fault_ff <= 16'h0000;
         glob_ff <= 1'b0;
      end else if (dev_clr) begin
         fault_ff <= 16'h0000;
         glob_ff <= 1'b0;
      end else begin
         fault_ff <= (cs_rise ? 16'h0000 : fault_ff) | chan_set; // [RULE8] [RULE15]
         glob_ff <= (cs_rise ? 1'b0 : glob_ff) | (|chan_set) | ov_s; // [RULE11]
      end
   end

   // ----------------------------------------------------------------------
   // Output protection
   // ----------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `NUM_OUT; gi = gi + 1) begin : g_chan
         channel_guard #(
            .SHORT_CYC(SHORT_CYC)
         ) u_guard (
            .i_clk_sys(i_clk_sys),
            .i_rst(i_rst),
            .i_clr(dev_clr),
            .i_cmd_on(onoff_ff[gi]),
            .i_short_dis(short_dis_ff[gi]),
            .i_retry(retry_ff),
            .i_ilim(ilim_s[gi]),
            .i_vds_hi(vds_s[gi]),
            .i_otemp(otemp_s[gi]),
            .o_drive(o_low_side_outputs[gi]),
            .o_short_evt(short_evt[gi]),
            .o_therm_evt(therm_evt[gi])
         );
      end
   endgenerate

   a_uv_logic_off: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE12]
      uvl_s |=> (onoff_ff == 16'h0000 && short_dis_ff == 16'h0000) ##1 (o_low_side_outputs == 16'h0000))
      else $error("logic undervoltage left outputs or registers set");
   a_uv_load_off: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE13]
      uvp_s |=> fault_ff == 16'h0000 ##1 (o_low_side_outputs == 16'h0000))
      else $error("load undervoltage left outputs on");
   a_pulldown_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE6]
      dev_clr |=> o_ol_pulldown_en == 16'h0000)
      else $error("pull-down stayed enabled in sleep");
   a_status_first: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE2]
      cs_fall |=> (sr_ff == $past(status)) && (o_miso == $past(status[23])) && (sr_ff[21:16] == 6'h00))
      else $error("frame did not start with the status word");
   a_echo_stage: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE1]
      (sclk_fall && bit_cnt_ff >= 6'h18) |=> o_miso == $past(sr_ff[23]))
      else $error("received bits not passed through");
   a_cmd_apply: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE3]
      (apply && op_is(sr_ff, `OP_ONOFF)) |=> onoff_ff == $past(sr_ff[15:0]))
      else $error("command word not applied on chip-select rise");
   a_filter_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE7]
      cs_rise |=> (filt_cnt_ff == FILT_LOAD) ##1 (ol_set == 16'h0000))
      else $error("open load sampled inside filter time");
   a_fault_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE15]
      (cs_rise && chan_set == 16'h0000 && !dev_clr) |=> fault_ff == 16'h0000)
      else $error("fault bits not cleared on chip-select rise");
   a_fault_latch: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE8]
      (ol_set != 16'h0000 && !dev_clr) |=> ((fault_ff & $past(ol_set)) == $past(ol_set)) && glob_ff)
      else $error("open load fault not latched");
   a_ol_only_off: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE5]
      $rose(fault_ff[0]) && !$past(ilim_s[0]) && !$past(short_evt[0]) && !$past(therm_evt[0]) |->
      !$past(onoff_ff[0]))
      else $error("open load flagged on an output commanded on");
   a_global_bit: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE11]
      (short_evt != 16'h0000 || therm_evt != 16'h0000) && !dev_clr |=> status[`RESP_GLOBAL_BIT])
      else $error("protection event did not set global fault bit");
endmodule

/* File: hdl/switch_fault_defs.svh */
// Shared constants of the switch fault manager: command codes, field
// positions and timing counts. Assumes a 10 MHz core clock.
`ifndef SWITCH_FAULT_DEFS_SVH
`define SWITCH_FAULT_DEFS_SVH

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define WORD_BITS 24
`define NUM_OUT 16
`define OP_MSB 23
`define OP_LSB 18
`define RESP_GLOBAL_BIT 23
`define RESP_OV_BIT 22
`define GLOBAL_RETRY_BIT 17
`define GLOBAL_OV_BIT 16

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define OP_ONOFF 6'h00
`define OP_OL_EN 6'h01
`define OP_GLOBAL 6'h02
`define OP_SHORT_OFF_DIS 6'h03
`define OP_RESET 6'h3F

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define REG16_RST 16'h0000
`define CLK_FREQ_MHZ 10
`define FILT_TIME_US 200
`define FILT_CYC (`FILT_TIME_US * `CLK_FREQ_MHZ)
`define SHORT_TIME_US 450
`define SHORT_CYC (`SHORT_TIME_US * `CLK_FREQ_MHZ)

`endif

/* File: hdl/switch_fault_pkg.sv */
// Types of the switch fault manager.
// Assumes nothing of its surroundings.
package switch_fault_pkg;
   // Thermal protection state of one output
   typedef enum logic [1:0] {
      TH_RUN = 2'b00,
      TH_HOT = 2'b01,
      TH_LOCK = 2'b10
   } therm_state_t;
endpackage

/* File: hdl/channel_guard.sv */
// Protection of one low-side output: fast short shutdown and thermal
// shutdown with retry. Assumes synchronized detector inputs.
`timescale 1ns/1ps
`include "switch_fault_defs.svh"

module channel_guard #(
   parameter int SHORT_CYC = `SHORT_CYC
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Control
   input wire logic i_clr,
   input wire logic i_cmd_on,
   input wire logic i_short_dis,
   input wire logic i_retry,
   // Detectors
   input wire logic i_ilim,
   input wire logic i_vds_hi,
   input wire logic i_otemp,
   // Results
   output logic o_drive,
   output logic o_short_evt,
   output logic o_therm_evt
);
   localparam logic [15:0] SHORT_LAST = 16'(SHORT_CYC - 1);

   switch_fault_pkg::therm_state_t state_ff;
   logic [15:0] short_cnt_ff;
   logic trip_ff;
   logic short_cond;

   assign short_cond = i_ilim & i_vds_hi & ~i_short_dis;

   // ----------------------------------------------------------------------
   // Fast short shutdown
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         short_cnt_ff <= 16'h0000;
         trip_ff <= 1'b0;
         o_short_evt <= 1'b0;
      end else begin
         o_short_evt <= 1'b0;
         if (i_clr || !i_cmd_on) begin
            short_cnt_ff <= 16'h0000;
            trip_ff <= 1'b0;
         end else if (!trip_ff && short_cond) begin
            short_cnt_ff <= short_cnt_ff + 16'h0001; // [RULE20]
            if (short_cnt_ff == SHORT_LAST) begin
               trip_ff <= 1'b1; // [RULE9]
               o_short_evt <= 1'b1;
            end
         end else if (!trip_ff) begin
            short_cnt_ff <= 16'h0000;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Thermal shutdown and retry
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state_ff <= switch_fault_pkg::TH_RUN;
         o_therm_evt <= 1'b0;
      end else begin
         o_therm_evt <= 1'b0;
         if (i_clr) begin
            state_ff <= switch_fault_pkg::TH_RUN;
         end else begin
            case (state_ff)
               switch_fault_pkg::TH_RUN: begin
                  if (i_otemp && i_cmd_on) begin
                     state_ff <= switch_fault_pkg::TH_HOT; // [RULE10]
                     o_therm_evt <= 1'b1;
                  end
               end
               switch_fault_pkg::TH_HOT: begin
                  if (!i_otemp) begin
                     state_ff <= i_retry ? switch_fault_pkg::TH_RUN : switch_fault_pkg::TH_LOCK; // [RULE14] [RULE17]
                  end
               end
               switch_fault_pkg::TH_LOCK: begin
                  if (!i_cmd_on) begin
                     state_ff <= switch_fault_pkg::TH_RUN;
                  end
               end
               default: begin
                  state_ff <= switch_fault_pkg::TH_RUN;
               end
            endcase
         end
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_drive <= 1'b0;
      end else begin
         o_drive <= i_cmd_on & ~i_clr & ~trip_ff & (state_ff == switch_fault_pkg::TH_RUN);
      end
   end

   a_short_off: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE9]
      (!trip_ff && i_cmd_on && !i_clr && short_cond && short_cnt_ff == SHORT_LAST) |-> ##2 !o_drive)
      else $error("output still driven after short persisted");
   a_therm_off: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE10]
      (state_ff == switch_fault_pkg::TH_RUN && i_otemp && i_cmd_on && !i_clr) |-> ##2 !o_drive)
      else $error("output still driven after thermal limit");
   a_lock_holds: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE17]
      (state_ff == switch_fault_pkg::TH_HOT && !i_otemp && !i_retry && !i_clr) |=>
      (state_ff == switch_fault_pkg::TH_LOCK) ##1 !o_drive)
      else $error("cooled output left lock without retry");
endmodule

/* File: bench/spi_master_model.sv */
// Behavioural serial master that stands on the far side of the fault manager.
// Assumes the bench calls xfer from one process; frames of 24 or 48 bits report a word.
`timescale 1ns/1ps

module spi_master_model (
   // Serial link
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_mosi,
   input wire logic i_miso,
   // Received word
   output logic [47:0] o_rx,
   output logic o_done
);
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_mosi = 1'b0;
      o_rx = 48'h0000_0000_0000;
      o_done = 1'b0;
   end

   // ----------------------------------------------------------------------
   // Frame transfer, mode 0, 800 ns link clock idle low between frames
   // ----------------------------------------------------------------------
   task automatic xfer(input int nbits, input logic [47:0] tx);
      logic [47:0] sh;
      logic [47:0] rx;
      sh = tx << (48 - nbits);
      rx = 48'h0000_0000_0000;
      #37;
      o_cs_n = 1'b0;
      #1000;
      for (int i = 0; i < nbits; i++) begin
         o_mosi = sh[47];
         sh = sh << 1;
         #400;
         o_sclk = 1'b1;
         rx = {rx[46:0], i_miso};
         #400;
         o_sclk = 1'b0;
      end
      #400;
      o_cs_n = 1'b1;
      // Released data line shows the inverse of its last value
      o_mosi = ~o_mosi;
      if (nbits % 24 == 0) begin
         o_rx = rx;
         o_done = 1'b1;
         #100;
         o_done = 1'b0;
      end
   endtask
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench of the switch fault manager.
// Assumes the serial master model and the design's header on the include path.
`timescale 1ns/1ps
`include "switch_fault_defs.svh"

module tb_top;
   logic clk_sys, rst, sclk, cs_n, mosi, miso, miso_oe_n, done, ov_resume;
   logic uv_logic, uv_load, ov_load;
   logic [15:0] ilim, vds_hi, otemp, ol_cmp, outs, pd_en;
   logic [47:0] rx;
   logic [47:0] exp_q[$];
   logic [23:0] rnd;
   int mismatches = 0;
   int n_tests = 0;

   switch_fault_manager #(.SHORT_CYC(20)) u_switch_fault_manager (
      .i_clk_sys(clk_sys), .i_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi),
      .o_miso(miso), .o_miso_oe_n(miso_oe_n), .i_uv_logic_supply(uv_logic),
      .i_uv_load_supply(uv_load), .i_ov_load_supply(ov_load), .i_ilim(ilim),
      .i_vds_hi(vds_hi), .i_otemp(otemp), .i_ol_cmp(ol_cmp),
      .o_low_side_outputs(outs), .o_ol_pulldown_en(pd_en), .o_ov_resume(ov_resume)
   );

   spi_master_model u_spi_master_model (
      .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso), .o_rx(rx), .o_done(done)
   );

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // ----------------------------------------------------------------------
   // Comparison, verdict and frame helpers
   // ----------------------------------------------------------------------
   task automatic cmp(input string what, input logic [47:0] e, input logic [47:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s exp %h got %h", what, e, g);
      end
   endtask

   // Pins are looked at mid-cycle, where they are settled
   task automatic cmp_pins(input logic [15:0] e_out, input logic [15:0] e_pd);
      @(negedge clk_sys);
      cmp("outputs", {32'h0000_0000, e_out}, {32'h0000_0000, outs});
      cmp("pulldown", {32'h0000_0000, e_pd}, {32'h0000_0000, pd_en});
      cmp("miso_oe_n", 48'h0000_0000_0001, {47'h0, miso_oe_n});
      @(posedge clk_sys);
   endtask

   task automatic tally_and_finish;
      if (exp_q.size() != 0) begin
         mismatches++;
      end
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   function automatic logic [23:0] cmd(input logic [5:0] op, input logic [17:0] d);
      return {op, d};
   endfunction

   // Words are spaced beyond the fault sensing time
   task automatic frame(input int n, input logic [47:0] tx, input logic [23:0] st);
      repeat (4600) @(posedge clk_sys);
      if (n % 24 == 0) begin
         exp_q.push_back(n == 48 ? {st, tx[47:24]} : {24'h00_0000, st});
      end
      u_spi_master_model.xfer(n, tx);
      repeat (20) @(posedge clk_sys);
   endtask

   // Response watcher: oldest note against each reported word
   always @(posedge done) begin
      if (exp_q.size() == 0) begin
         mismatches++;
         $display("mismatch response exp none got %h", rx);
      end else begin
         cmp("response", exp_q.pop_front(), rx);
      end
   end

   initial begin
      repeat (95000) @(posedge clk_sys);
      mismatches++;
      tally_and_finish();
   end

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      rst = 1'b1;
      {uv_logic, uv_load, ov_load} = 3'h0;
      {ilim, vds_hi, otemp, ol_cmp} = 64'h0000_0000_0000_0000;
      rnd = 24'($urandom(65300));
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (5) @(posedge clk_sys);
      cmp_pins(16'h0000, 16'h0000);
      frame(48, {rnd, cmd(`OP_ONOFF, 18'h0_0068)}, 24'h00_0000);
      cmp_pins(16'h0068, 16'h0000);
      frame(16, {32'h0000_0000, 16'h0000}, 24'h00_0000);
      cmp_pins(16'h0068, 16'h0000);
      otemp <= 16'h0008;
      repeat (10) @(posedge clk_sys);
      cmp_pins(16'h0060, 16'h0000);
      otemp <= 16'h0000;
      repeat (20) @(posedge clk_sys);
      cmp_pins(16'h0060, 16'h0000);
      frame(24, {24'h00_0000, cmd(`OP_GLOBAL, 18'h3_0000)}, 24'h80_0008);
      cmp("ov_resume", 48'h0000_0000_0001, {47'h0, ov_resume});
      frame(24, {24'h00_0000, cmd(`OP_ONOFF, 18'h0_0060)}, 24'h00_0000);
      frame(24, {24'h00_0000, cmd(`OP_ONOFF, 18'h0_0068)}, 24'h00_0000);
      otemp <= 16'h0008;
      repeat (10) @(posedge clk_sys);
      cmp_pins(16'h0060, 16'h0000);
      otemp <= 16'h0000;
      repeat (20) @(posedge clk_sys);
      cmp_pins(16'h0068, 16'h0000);
      frame(24, {24'h00_0000, cmd(`OP_SHORT_OFF_DIS, 18'h0_0040)}, 24'h80_0008);
      ilim <= 16'h0060;
      vds_hi <= 16'h0060;
      repeat (60) @(posedge clk_sys);
      cmp_pins(16'h0048, 16'h0000);
      ilim <= 16'h0000;
      vds_hi <= 16'h0000;
      frame(24, {24'h00_0000, cmd(`OP_OL_EN, 18'h0_0009)}, 24'h80_0060);
      cmp_pins(16'h0048, 16'h0009);
      ol_cmp <= 16'h0009;
      repeat (1000) @(posedge clk_sys);
      ol_cmp <= 16'h0000;
      frame(24, {24'h00_0000, cmd(`OP_OL_EN, 18'h0_0009)}, 24'h00_0000);
      repeat (2500) @(posedge clk_sys);
      ol_cmp <= 16'h0009;
      repeat (50) @(posedge clk_sys);
      ol_cmp <= 16'h0000;
      frame(24, {24'h00_0000, cmd(`OP_OL_EN, 18'h0_0009)}, 24'h80_0001);
      ov_load <= 1'b1;
      frame(24, {24'h00_0000, cmd(`OP_OL_EN, 18'h0_0009)}, 24'hC0_0000);
      ov_load <= 1'b0;
      uv_logic <= 1'b1;
      repeat (10) @(posedge clk_sys);
      cmp_pins(16'h0000, 16'h0000);
      cmp("ov_resume", 48'h0000_0000_0000, {47'h0, ov_resume});
      uv_logic <= 1'b0;
      frame(24, {24'h00_0000, cmd(`OP_ONOFF, 18'h0_00FF)}, 24'h00_0000);
      cmp_pins(16'h00FF, 16'h0000);
      uv_load <= 1'b1;
      repeat (10) @(posedge clk_sys);
      cmp_pins(16'h0000, 16'h0000);
      uv_load <= 1'b0;
      tally_and_finish();
   end
endmodule
